//--- pmrc_pkg.sv
// shared constants and types for the power mode and reset control block
package pmrc_pkg;
   // power modes requested by software
   typedef enum logic [2:0] {
      PMRC_MODE_RUN,
      PMRC_MODE_SLEEP,
      PMRC_MODE_DEEP_SLEEP,
      PMRC_MODE_POWER_DOWN,
      PMRC_MODE_DEEP_PD
   } pmrc_mode_t;
   // protection levels
   localparam logic [1:0] PMRC_PROT_NONE = 2'h0;
   localparam logic [1:0] PMRC_PROT_ONE = 2'h1;
   localparam logic [1:0] PMRC_PROT_TWO = 2'h2;
   localparam logic [1:0] PMRC_PROT_THREE = 2'h3;
   // clock period and reset pin minimum pulse
   localparam int PMRC_CLK_PS = 5000;
   localparam int PMRC_RST_MIN_NS = 50;
   localparam int PMRC_RST_MIN_CYC_RAW = (PMRC_RST_MIN_NS * 1000 + PMRC_CLK_PS - 1) / PMRC_CLK_PS;
   localparam int PMRC_RST_MIN_CYC = (PMRC_RST_MIN_CYC_RAW < 1) ? 1 : PMRC_RST_MIN_CYC_RAW;
   // internal reset stretch after all sources clear
   localparam int PMRC_RST_HOLD_CYC = 16;
   // wake latencies: power-down slower than deep-sleep
   localparam int PMRC_WAKE_DS_CYC = 4;
   localparam int PMRC_WAKE_PD_CYC = 32;
   // boot fetch address
   localparam logic [31:0] PMRC_BOOT_ADDR = 32'h0000_0000;
   // breakpoint and watchpoint counts
   localparam int PMRC_NUM_BKPT = 4;
   localparam int PMRC_NUM_WATCH = 2;
   // reset source bit positions
   localparam int PMRC_SRC_PIN = 0;
   localparam int PMRC_SRC_WDT = 1;
   localparam int PMRC_SRC_POR = 2;
   localparam int PMRC_SRC_BROWN = 3;
endpackage : pmrc_pkg

//--- pmrc_sync_if.sv
// carrier between the top and its pin synchroniser
`timescale 1ns/1ps
interface pmrc_sync_if;
   logic rst_pin_n; // filtered reset pin level
   logic rst_fall; // reset pin went low
   logic wake_pin_n; // filtered wake pin level
   logic wake_fall; // wake pin went low
   modport sync (output rst_pin_n, output rst_fall, output wake_pin_n, output wake_fall);
   modport user (input rst_pin_n, input rst_fall, input wake_pin_n, input wake_fall);
endinterface : pmrc_sync_if

//--- pmrc_pin_sync.sv
// three-stage synchronisers for the reset and wake pins
`timescale 1ns/1ps
module pmrc_pin_sync
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic rst_pin_n_i,
   input wire logic wake_pin_n_i,
   pmrc_sync_if.sync sync_o
);
   import pmrc_pkg::*;
   logic [2:0] rst_sh_reg; // reset pin shift chain
   logic [2:0] wake_sh_reg; // wake pin shift chain
   logic rst_lvl_reg; // accepted reset pin level
   logic wake_lvl_reg; // accepted wake pin level

   // shift chains; pins idle high so reset to one
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rst_sh_reg <= 3'h7;
         wake_sh_reg <= 3'h7;
      end
      else
      begin
         rst_sh_reg <= {rst_sh_reg[1:0], rst_pin_n_i};
         wake_sh_reg <= {wake_sh_reg[1:0], wake_pin_n_i};
      end
   end

   // accept a level only once stages two and three agree
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rst_lvl_reg <= 1'h1;
         wake_lvl_reg <= 1'h1;
      end
      else
      begin
         if (rst_sh_reg[1] == rst_sh_reg[2])
            rst_lvl_reg <= rst_sh_reg[2];
         if (wake_sh_reg[1] == wake_sh_reg[2])
            wake_lvl_reg <= wake_sh_reg[2];
      end
   end

   assign sync_o.rst_pin_n = rst_lvl_reg;
   assign sync_o.wake_pin_n = wake_lvl_reg;
   assign sync_o.rst_fall = rst_lvl_reg && (rst_sh_reg[1] == rst_sh_reg[2]) && !rst_sh_reg[2];
   assign sync_o.wake_fall = wake_lvl_reg && (wake_sh_reg[1] == wake_sh_reg[2]) && !wake_sh_reg[2];
endmodule : pmrc_pin_sync

//--- pmrc_top.sv
// power mode sequencing, reset merging, brown-out and protection control
`timescale 1ns/1ps
module pmrc_top
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire pmrc_pkg::pmrc_mode_t mode_req_i, // mode on sleep request
   input wire logic sleep_req_i, // core executed wait-for-interrupt
   input wire logic pd_lock_i, // deep power-down lock bit
   input wire logic wdt_osc_keep_i, // keep watchdog osc in deep-sleep/pd
   input wire logic wdt_sel_rc_i, // watchdog clocked from rc osc
   input wire logic brown_keep_i, // keep brown-out monitor in deep-sleep/pd
   input wire logic irq_any_i, // any enabled interrupt pending
   input wire logic gpio_wake_i, // selected gpio wake event
   input wire logic wdt_irq_i, // watchdog timer interrupt
   input wire logic usb_wake_i, // usb activity interrupt
   input wire logic wdt_reset_i, // watchdog reset request
   input wire logic por_i, // power-on reset from analog
   input wire logic [1:0] brown_irq_level_i, // brown-out interrupt level select
   input wire logic [1:0] brown_rst_level_i, // brown-out reset level select
   input wire logic brown_rst_en_i, // brown-out reset enable
   input wire logic [3:0] brown_cmp_i, // supply below level n comparators
   input wire logic rst_pin_n_i, // external reset pin
   input wire logic wake_pin_n_i, // wake pin, active low
   input wire logic [31:0] prot_word_i, // protection word read from flash
   input wire logic prog_pin_dis_i, // disable pin-triggered programming entry
   input wire logic [pmrc_pkg::PMRC_NUM_BKPT-1:0] bkpt_hit_i, // breakpoint comparators
   input wire logic [pmrc_pkg::PMRC_NUM_WATCH-1:0] watch_hit_i, // watchpoint comparators
   output logic core_clk_en_o, // core clock gate enable
   output logic periph_clk_en_o, // peripheral clock gate enable
   output logic rc_osc_en_o, // rc oscillator running
   output logic rc_out_en_o, // rc oscillator output gate
   output logic sys_osc_en_o, // system osc and plls allowed
   output logic wdt_osc_en_o, // watchdog oscillator running
   output logic analog_en_o, // analog blocks powered
   output logic flash_standby_o, // flash in standby
   output logic flash_off_o, // flash shut down
   output logic flash_init_o, // flash controller init pulse
   output logic brown_en_o, // brown-out monitor powered
   output logic brown_irq_o, // brown-out interrupt request
   output logic brown_stat_o, // brown-out status bit
   output logic main_pwr_en_o, // main domain power
   output logic core_rst_n_o, // internal chip reset, active low
   output logic [31:0] boot_addr_o, // first fetch address
   output logic [3:0] rst_cause_o, // latched reset sources
   output logic [1:0] prot_level_o, // active protection level
   output logic debug_en_o, // serial wire debug allowed
   output logic jtag_sel_o, // boundary scan selected
   output logic prog_limited_o, // limited programming set, no sector 0
   output logic prog_full_erase_o, // programming only full erase
   output logic prog_en_o, // in-system programming allowed
   output logic prog_pin_en_o, // pin-triggered programming entry allowed
   output logic halt_req_o, // debug halt from break/watch hit
   output logic pd_refused_o, // last deep power-down request refused
   output pmrc_pkg::pmrc_mode_t mode_o // current power mode
);
   import pmrc_pkg::*;

   // pin synchroniser carrier
   pmrc_sync_if pins ();
   pmrc_pin_sync u_sync
   (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .rst_pin_n_i(rst_pin_n_i),
      .wake_pin_n_i(wake_pin_n_i),
      .sync_o(pins)
   );

   // wake event decode shared by deep-sleep and power-down
   function automatic logic wake_hit(input logic g, input logic w, input logic u);
      wake_hit = g | w | u;
   endfunction : wake_hit

   pmrc_mode_t mode_reg; // current mode
   logic [5:0] wake_cnt_reg; // wake latency counter
   logic waking_reg; // clocks restarted, core clock pending
   logic wake_ev_reg; // registered wake event
   logic [3:0] pin_low_cnt_reg; // reset pin low duration
   logic pin_rst_reg; // reset pin qualified
   logic [4:0] hold_cnt_reg; // internal reset stretch
   logic int_rst_reg; // internal reset active
   logic dpd_wake_reg; // wake from deep power-down pending reset
   logic brown_rst_reg; // brown-out reset condition
   logic brown_irq_reg; // brown-out below interrupt level
   logic any_src; // any reset source now

   // brown-out comparisons against selected levels
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         brown_irq_reg <= 1'h0;
         brown_rst_reg <= 1'h0;
      end
      else
      begin
         brown_irq_reg <= brown_en_o & brown_cmp_i[brown_irq_level_i];
         brown_rst_reg <= brown_en_o & brown_rst_en_i & brown_cmp_i[brown_rst_level_i];
      end
   end

   // reset pin must stay low long enough to count
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         pin_low_cnt_reg <= 4'h0;
         pin_rst_reg <= 1'h0;
      end
      else if (pins.rst_pin_n)
      begin
         pin_low_cnt_reg <= 4'h0;
         pin_rst_reg <= 1'h0;
      end
      else if (pin_low_cnt_reg < 4'(PMRC_RST_MIN_CYC - 1))
         pin_low_cnt_reg <= pin_low_cnt_reg + 4'h1;
      else
         pin_rst_reg <= 1'h1;
   end

   // merge every reset source, deep power-down wake included
   assign any_src = pin_rst_reg | wdt_reset_i | por_i | brown_rst_reg | dpd_wake_reg;

   // stretch internal reset after the last source drops
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         int_rst_reg <= 1'h1;
         hold_cnt_reg <= 5'h0;
      end
      else if (any_src)
      begin
         int_rst_reg <= 1'h1;
         hold_cnt_reg <= 5'h0;
      end
      else if (int_rst_reg)
      begin
         if (hold_cnt_reg == 5'(PMRC_RST_HOLD_CYC - 1))
            int_rst_reg <= 1'h0;
         else
            hold_cnt_reg <= hold_cnt_reg + 5'h1;
      end
   end

   // latch reset causes; cleared only by rst_n_i or power-on
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         rst_cause_o <= 4'h0;
      else if (por_i)
         rst_cause_o <= 4'(1 << PMRC_SRC_POR);
      else
      begin
         if (pin_rst_reg) rst_cause_o[PMRC_SRC_PIN] <= 1'h1;
         if (wdt_reset_i) rst_cause_o[PMRC_SRC_WDT] <= 1'h1;
         if (brown_rst_reg) rst_cause_o[PMRC_SRC_BROWN] <= 1'h1;
      end
   end

   // register the wake sources before acting on them
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         wake_ev_reg <= 1'h0;
      else
         wake_ev_reg <= wake_hit(gpio_wake_i, wdt_irq_i, usb_wake_i);
   end

   // power mode sequencer
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i || int_rst_reg)
      begin
         mode_reg <= PMRC_MODE_RUN;
         waking_reg <= 1'h0;
         wake_cnt_reg <= 6'h0;
         pd_refused_o <= 1'h0;
         dpd_wake_reg <= 1'h0;
      end
      else
      begin
         case (mode_reg)
            PMRC_MODE_RUN:
            begin
               waking_reg <= 1'h0;
               if (sleep_req_i)
               begin
                  if (mode_req_i == PMRC_MODE_DEEP_PD && pd_lock_i)
                  begin
                     pd_refused_o <= 1'h1;
                     mode_reg <= PMRC_MODE_SLEEP;
                  end
                  else
                  begin
                     pd_refused_o <= 1'h0;
                     mode_reg <= mode_req_i;
                  end
               end
            end
            PMRC_MODE_SLEEP:
               if (irq_any_i)
                  mode_reg <= PMRC_MODE_RUN;
            PMRC_MODE_DEEP_SLEEP, PMRC_MODE_POWER_DOWN:
            begin
               // clocks come back first, core clock after latency
               if (waking_reg)
               begin
                  if (wake_cnt_reg == 6'h0)
                     mode_reg <= PMRC_MODE_RUN;
                  else
                     wake_cnt_reg <= wake_cnt_reg - 6'h1;
               end
               else if (wake_ev_reg)
               begin
                  waking_reg <= 1'h1;
                  wake_cnt_reg <= (mode_reg == PMRC_MODE_POWER_DOWN) ?
                     6'(PMRC_WAKE_PD_CYC - 1) : 6'(PMRC_WAKE_DS_CYC - 1);
               end
            end
            PMRC_MODE_DEEP_PD:
               // only the wake pin ends this mode, via full reset
               if (pins.wake_fall)
                  dpd_wake_reg <= 1'h1;
            default:
               mode_reg <= PMRC_MODE_RUN;
         endcase
      end
   end

   // clock, oscillator and power gates per mode
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         core_clk_en_o <= 1'h0;
         periph_clk_en_o <= 1'h0;
         rc_osc_en_o <= 1'h1;
         rc_out_en_o <= 1'h1;
         sys_osc_en_o <= 1'h0;
         wdt_osc_en_o <= 1'h0;
         analog_en_o <= 1'h0;
         flash_standby_o <= 1'h0;
         flash_off_o <= 1'h0;
         brown_en_o <= 1'h1;
         main_pwr_en_o <= 1'h1;
      end
      else if (int_rst_reg)
      begin
         // rc runs from reset so boot has a known clock
         core_clk_en_o <= 1'h0;
         periph_clk_en_o <= 1'h0;
         rc_osc_en_o <= 1'h1;
         rc_out_en_o <= 1'h1;
         sys_osc_en_o <= 1'h0;
         wdt_osc_en_o <= 1'h0;
         analog_en_o <= 1'h1;
         flash_standby_o <= 1'h0;
         flash_off_o <= 1'h0;
         brown_en_o <= 1'h1;
         main_pwr_en_o <= 1'h1;
      end
      else
      begin
         case (mode_reg)
            PMRC_MODE_RUN, PMRC_MODE_SLEEP:
            begin
               core_clk_en_o <= (mode_reg == PMRC_MODE_RUN);
               periph_clk_en_o <= 1'h1;
               rc_osc_en_o <= 1'h1;
               rc_out_en_o <= 1'h1;
               sys_osc_en_o <= 1'h1;
               wdt_osc_en_o <= 1'h1;
               analog_en_o <= 1'h1;
               flash_standby_o <= 1'h0;
               flash_off_o <= 1'h0;
               brown_en_o <= 1'h1;
               main_pwr_en_o <= 1'h1;
            end
            PMRC_MODE_DEEP_SLEEP, PMRC_MODE_POWER_DOWN:
            begin
               // while waking, sources return before the core clock
               core_clk_en_o <= 1'h0;
               periph_clk_en_o <= waking_reg;
               rc_osc_en_o <= waking_reg || (mode_reg == PMRC_MODE_DEEP_SLEEP);
               rc_out_en_o <= waking_reg || (mode_reg == PMRC_MODE_DEEP_SLEEP && wdt_sel_rc_i);
               sys_osc_en_o <= waking_reg;
               wdt_osc_en_o <= waking_reg || wdt_osc_keep_i;
               analog_en_o <= waking_reg;
               flash_standby_o <= !waking_reg && (mode_reg == PMRC_MODE_DEEP_SLEEP);
               flash_off_o <= !waking_reg && (mode_reg == PMRC_MODE_POWER_DOWN);
               brown_en_o <= waking_reg || brown_keep_i;
               main_pwr_en_o <= 1'h1;
            end
            PMRC_MODE_DEEP_PD:
            begin
               // everything off but the wake pin logic
               core_clk_en_o <= 1'h0;
               periph_clk_en_o <= 1'h0;
               rc_osc_en_o <= 1'h0;
               rc_out_en_o <= 1'h0;
               sys_osc_en_o <= 1'h0;
               wdt_osc_en_o <= 1'h0;
               analog_en_o <= 1'h0;
               flash_standby_o <= 1'h0;
               flash_off_o <= 1'h1;
               brown_en_o <= 1'h0;
               main_pwr_en_o <= 1'h0;
            end
            default:
            begin
               core_clk_en_o <= 1'h0;
            end
         endcase
      end
   end

   // reset outputs: flash init pulse, core reset, boot vector
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         flash_init_o <= 1'h0;
         core_rst_n_o <= 1'h0;
         boot_addr_o <= PMRC_BOOT_ADDR;
      end
      else
      begin
         flash_init_o <= any_src && !int_rst_reg;
         core_rst_n_o <= !int_rst_reg;
         boot_addr_o <= PMRC_BOOT_ADDR;
      end
   end

   // brown-out interrupt and status
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         brown_irq_o <= 1'h0;
         brown_stat_o <= 1'h0;
      end
      else
      begin
         brown_irq_o <= brown_irq_reg;
         brown_stat_o <= brown_irq_reg;
      end
   end

   // protection level decode; pattern values are parameters of the package style
   localparam logic [31:0] PAT_ONE = 32'h1234_5678;
   localparam logic [31:0] PAT_TWO = 32'h8765_4321;
   localparam logic [31:0] PAT_THREE = 32'h4321_8765;
   logic [1:0] lvl; // decoded level
   always_comb
   begin
      case (prot_word_i)
         PAT_ONE: lvl = PMRC_PROT_ONE;
         PAT_TWO: lvl = PMRC_PROT_TWO;
         PAT_THREE: lvl = PMRC_PROT_THREE;
         default: lvl = PMRC_PROT_NONE;
      endcase
   end

   // protection and test port selection; level sampled only in reset
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         prot_level_o <= PMRC_PROT_NONE;
         debug_en_o <= 1'h0;
         jtag_sel_o <= 1'h0;
         prog_limited_o <= 1'h0;
         prog_full_erase_o <= 1'h0;
         prog_en_o <= 1'h0;
         prog_pin_en_o <= 1'h0;
      end
      else
      begin
         if (int_rst_reg)
            prot_level_o <= lvl;
         // debug port off in reset or at any protection level
         debug_en_o <= !int_rst_reg && pins.rst_pin_n && (prot_level_o == PMRC_PROT_NONE);
         jtag_sel_o <= !pins.rst_pin_n;
         prog_limited_o <= (prot_level_o == PMRC_PROT_ONE);
         prog_full_erase_o <= (prot_level_o == PMRC_PROT_TWO);
         prog_en_o <= (prot_level_o != PMRC_PROT_THREE);
         prog_pin_en_o <= (prot_level_o != PMRC_PROT_THREE) && !prog_pin_dis_i;
      end
   end

   // debug halt from any of the comparators
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         halt_req_o <= 1'h0;
      else
         halt_req_o <= debug_en_o && ((|bkpt_hit_i) || (|watch_hit_i));
   end

   assign mode_o = mode_reg;

   // assertions
   sequence s_sleep_irq;
      mode_reg == PMRC_MODE_SLEEP && irq_any_i && !int_rst_reg;
   endsequence
   sleep_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_sleep_irq |=> ##1 core_clk_en_o) else $error("core clock not back after sleep");
   dpd_lock_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_reg == PMRC_MODE_RUN && sleep_req_i && pd_lock_i && !int_rst_reg
       && mode_req_i == PMRC_MODE_DEEP_PD) |=> mode_reg != PMRC_MODE_DEEP_PD)
      else $error("locked deep power-down entered");
   reset_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      any_src |=> ##1 !core_rst_n_o) else $error("reset source did not hold core");
   debug_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (prot_level_o != PMRC_PROT_NONE) |=> !debug_en_o) else $error("debug open when protected");
   prog_lock_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(prot_level_o) == PMRC_PROT_THREE |-> !prog_pin_en_o && !prog_en_o)
      else $error("programming open at level three");
   dpd_power_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_reg == PMRC_MODE_DEEP_PD && !int_rst_reg) |=> !main_pwr_en_o)
      else $error("power on in deep power-down");
   // deep-sleep or power-down handing over to run without an internal reset
   sequence s_deep_wake;
      (mode_reg == PMRC_MODE_DEEP_SLEEP || mode_reg == PMRC_MODE_POWER_DOWN) && !int_rst_reg
      ##1 (mode_reg == PMRC_MODE_RUN && !int_rst_reg);
   endsequence
   wake_order_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_deep_wake |-> periph_clk_en_o && sys_osc_en_o && !core_clk_en_o)
      else $error("core clock before sources");
   ds_flash_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_reg == PMRC_MODE_DEEP_SLEEP && !waking_reg && !int_rst_reg) |=> flash_standby_o)
      else $error("flash not in standby");
endmodule : pmrc_top

//--- pmrc_pin_model.sv
// external reset and wake pin model, both pins pulled up when released
`timescale 1ns/1ps
module pmrc_pin_model
(
   input wire logic sys_clk_i,
   input wire logic rst_go_i, // start a low pulse on the reset pin
   input wire logic wake_go_i, // start a low pulse on the wake pin
   input wire logic [7:0] low_cyc_i, // pulse length in clock cycles
   output logic rst_pin_n_o,
   output logic wake_pin_n_o
);
   int rst_cnt = 0; // cycles left with reset pin low
   int wake_cnt = 0; // cycles left with wake pin low
   // counts step on the rising edge, so a go pulse set at the falling edge is seen once
   always @(posedge sys_clk_i)
   begin
      rst_cnt <= rst_go_i ? int'(low_cyc_i) : (rst_cnt > 0 ? rst_cnt - 1 : 0);
      wake_cnt <= wake_go_i ? int'(low_cyc_i) : (wake_cnt > 0 ? wake_cnt - 1 : 0);
   end
   // released pins go to the pull-up level, never a stale value
   assign rst_pin_n_o = (rst_cnt == 0);
   assign wake_pin_n_o = (wake_cnt == 0);
endmodule : pmrc_pin_model

//--- test_power_mode_reset_control.sv
// self-checking bench for the power mode and reset control block
`timescale 1ns/1ps
module test_power_mode_reset_control;
   import pmrc_pkg::*;
   logic sys_clk_i = 0, rst_n_i = 0, sleep_req_i = 0, pd_lock_i = 0, irq_any_i = 0;
   logic wdt_osc_keep_i = 1, wdt_sel_rc_i = 0, brown_keep_i = 1, wdt_reset_i = 0, por_i = 0;
   logic gpio_wake_i = 0, wdt_irq_i = 0, usb_wake_i = 0, brown_rst_en_i = 0, prog_pin_dis_i = 0;
   logic [1:0] brown_irq_level_i = 0, brown_rst_level_i = 0, watch_hit_i = 0;
   logic [3:0] brown_cmp_i = 0, bkpt_hit_i = 0, rst_cause_o;
   logic [31:0] prot_word_i = 0, boot_addr_o;
   pmrc_mode_t mode_req_i = PMRC_MODE_RUN, mode_o;
   logic rst_pin_n_i, wake_pin_n_i, core_clk_en_o, periph_clk_en_o, rc_osc_en_o, rc_out_en_o;
   logic sys_osc_en_o, wdt_osc_en_o, analog_en_o, flash_standby_o, flash_off_o, flash_init_o;
   logic brown_en_o, brown_irq_o, brown_stat_o, main_pwr_en_o, core_rst_n_o, debug_en_o;
   logic jtag_sel_o, prog_limited_o, prog_full_erase_o, prog_en_o, prog_pin_en_o, halt_req_o;
   logic pd_refused_o, rst_go = 0, wake_go = 0;
   logic [1:0] prot_level_o, lvl;
   logic [7:0] low_cyc = 8'h1E;
   logic [31:0] pat [4] = '{32'h0, 32'h12345678, 32'h87654321, 32'h43218765}; // level table
   int err_total = 0, comparisons = 0, k, src, lat, dlat;
   pmrc_top dut_u (.*);
   pmrc_pin_model pin_u (.sys_clk_i(sys_clk_i), .rst_go_i(rst_go), .wake_go_i(wake_go),
      .low_cyc_i(low_cyc), .rst_pin_n_o(rst_pin_n_i), .wake_pin_n_o(wake_pin_n_i));
   // 200 MHz clock
   always #2.5 sys_clk_i = ~sys_clk_i;
   // reference model: expected gates per mode, core/periph/analog/standby/off
   function automatic logic [4:0] gates(input pmrc_mode_t m);
      case (m)
         PMRC_MODE_RUN: return 5'h1C;
         PMRC_MODE_SLEEP: return 5'h0C; // core stops, peripherals run
         PMRC_MODE_DEEP_SLEEP: return 5'h02; // flash standby, analog off
         default: return 5'h01; // power-down: flash shut down
      endcase
   endfunction : gates
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc
   // bounded wait for the internal reset to release
   task wait_rst;
      for (int i = 0; i < 300 && core_rst_n_o !== 1'b1; i++)
         cyc(1);
      chk(core_rst_n_o, 1);
   endtask : wait_rst
   // bounded wait for a mode, reporting the cycles taken
   task wait_mode(input pmrc_mode_t m, output int n);
      for (n = 0; n < 80 && mode_o !== m; n++)
         cyc(1);
      chk(mode_o, m);
   endtask : wait_mode
   task enter(input pmrc_mode_t m);
      mode_req_i = m;
      sleep_req_i = 1;
      cyc(1);
      sleep_req_i = 0;
   endtask : enter
   task pulse(input logic on_rst, input logic [7:0] n);
      low_cyc = n;
      rst_go = on_rst;
      wake_go = !on_rst;
      cyc(1);
      {rst_go, wake_go} = 2'h0;
   endtask : pulse
   task summarize;
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // watchdog well beyond the expected run length
   initial
   begin
      #100us;
      err_total++;
      summarize;
   end
   initial
   begin
      void'($urandom(18));
      cyc(10);
      rst_n_i = 1;
      wait_rst;
      chk(boot_addr_o, PMRC_BOOT_ADDR);
      chk(rc_osc_en_o, 1);
      // every protection level, loaded through a reset pin pulse
      for (k = 0; k < 4; k++)
      begin
         prot_word_i = pat[k];
         prog_pin_dis_i = 1'($urandom_range(1, 0));
         pulse(1, 8'h1E);
         cyc(20);
         chk({core_rst_n_o, rst_cause_o[PMRC_SRC_PIN]}, 2'h1);
         chk({jtag_sel_o, debug_en_o}, 2'h2);
         wait_rst;
         chk(prot_level_o, k);
         chk(debug_en_o, k == 0);
         chk({prog_limited_o, prog_full_erase_o}, {k == 1, k == 2});
         chk(prog_en_o, k != 3);
         chk(prog_pin_en_o, k != 3 && !prog_pin_dis_i);
      end
      // back to no protection, picked up by the next reset so halts are allowed
      prot_word_i = pat[0];
      // sleep woken by an interrupt, deep-sleep and power-down each with a random wake source
      for (k = 1; k < 4; k++)
      begin
         {wdt_sel_rc_i, wdt_osc_keep_i, brown_keep_i} = 3'($urandom);
         enter(pmrc_mode_t'(k));
         wait_mode(pmrc_mode_t'(k), lat);
         cyc(3);
         chk({core_clk_en_o, periph_clk_en_o, analog_en_o, flash_standby_o, flash_off_o},
            gates(pmrc_mode_t'(k)));
         chk({rc_osc_en_o, rc_out_en_o, wdt_osc_en_o, brown_en_o}, {k != 3,
            k == 1 || (k == 2 && wdt_sel_rc_i), k == 1 || wdt_osc_keep_i,
            k == 1 || brown_keep_i});
         src = $urandom_range(2, 0);
         irq_any_i = (k == 1);
         {gpio_wake_i, wdt_irq_i, usb_wake_i} = (k == 1) ? 3'h0 : 3'(1 << src);
         cyc(1);
         {irq_any_i, gpio_wake_i, wdt_irq_i, usb_wake_i} = 4'h0;
         wait_mode(PMRC_MODE_RUN, lat);
         cyc(3);
         chk({core_clk_en_o, periph_clk_en_o, sys_osc_en_o}, 3'h7);
         if (k == 2)
            dlat = lat;
      end
      chk(dlat < lat, 1);
      // locked deep power-down falls back to sleep
      pd_lock_i = 1;
      enter(PMRC_MODE_DEEP_PD);
      wait_mode(PMRC_MODE_SLEEP, lat);
      chk(pd_refused_o, 1);
      irq_any_i = 1;
      cyc(1);
      irq_any_i = 0;
      wait_mode(PMRC_MODE_RUN, lat);
      pd_lock_i = 0;
      enter(PMRC_MODE_DEEP_PD);
      wait_mode(PMRC_MODE_DEEP_PD, lat);
      gpio_wake_i = 1;
      cyc(10);
      gpio_wake_i = 0;
      chk({mode_o, main_pwr_en_o}, {PMRC_MODE_DEEP_PD, 1'b0});
      pulse(0, 8'h05);
      cyc(8);
      chk(core_rst_n_o, 0);
      wait_rst;
      chk({mode_o, rc_osc_en_o}, {PMRC_MODE_RUN, 1'b1});
      // brown-out interrupt, then forced reset
      lvl = 2'($urandom_range(3, 0));
      brown_irq_level_i = lvl;
      brown_cmp_i = 4'(1 << lvl);
      cyc(4);
      chk({brown_irq_o, brown_stat_o}, 2'h3);
      brown_rst_level_i = lvl;
      brown_rst_en_i = 1;
      cyc(4);
      chk({core_rst_n_o, rst_cause_o[PMRC_SRC_BROWN]}, 2'h1);
      brown_cmp_i = 4'h0;
      wait_rst;
      // watchdog reset with its flash init pulse, then power-on clears the causes
      wdt_reset_i = 1;
      cyc(1);
      chk({flash_init_o, rst_cause_o[PMRC_SRC_WDT]}, 2'h3);
      wdt_reset_i = 0;
      por_i = 1;
      cyc(2);
      por_i = 0;
      chk(rst_cause_o, 4'(1 << PMRC_SRC_POR));
      wait_rst;
      // break and watch hits
      bkpt_hit_i = 4'(1 << $urandom_range(3, 0));
      watch_hit_i = 2'h2;
      cyc(3);
      chk(halt_req_o, 1);
      summarize;
   end
endmodule : test_power_mode_reset_control
